/* common/rrpa_pkg.sv */
// Constants and types for the relay remote parameter access block
package rrpa_pkg;

  // Parameter kinds on the serial request port
  typedef enum logic [1:0] {
    RRPA_KIND_IN  = 2'h0,
    RRPA_KIND_OUT = 2'h1,
    RRPA_KIND_VAR = 2'h2,
    RRPA_KIND_SET = 2'h3
  } rrpa_kind_t;

  localparam int NUM_W  = 8;
  localparam int DATA_W = 16;
  localparam int PW_W   = 10;

  // Input parameter numbers
  localparam logic [NUM_W-1:0] IN_PH1   = 8'h01;
  localparam logic [NUM_W-1:0] IN_PH2   = 8'h02;
  localparam logic [NUM_W-1:0] IN_PH3   = 8'h03;
  localparam logic [NUM_W-1:0] IN_RES   = 8'h04;
  localparam logic [NUM_W-1:0] IN_DIFF  = 8'h05;
  localparam logic [NUM_W-1:0] IN_CTLA  = 8'h06;
  localparam logic [NUM_W-1:0] IN_CTLB  = 8'h07;
  localparam logic [NUM_W-1:0] IN_RRST  = 8'h08;

  // Stage flag numbers: state 1..11, recorded 21..31
  localparam int NSTAGE = 11;
  localparam logic [NUM_W-1:0] OUT_NOW_BASE  = 8'h01;
  localparam logic [NUM_W-1:0] OUT_SEEN_BASE = 8'h15;

  // Password parameters
  localparam logic [NUM_W-1:0] VAR_PW_OPEN  = 8'hA0;
  localparam logic [NUM_W-1:0] VAR_PW_CLOSE = 8'hA1;

  // Password values and lockout
  localparam logic [PW_W-1:0] PW_DEFAULT = 10'h001;
  localparam logic [PW_W-1:0] PW_MIN     = 10'h001;
  localparam logic [PW_W-1:0] PW_MAX     = 10'h3E7;
  localparam logic [PW_W-1:0] PW_LOCKED  = 10'h000;
  localparam logic [2:0]      FAIL_LIMIT = 3'h7;

  // Measured value limits, in raw counts
  localparam logic [DATA_W-1:0] PH_MAX   = 16'h003F;
  localparam logic [DATA_W-1:0] RES_MAX  = 16'h0015;
  localparam logic [DATA_W-1:0] DIFF_MIN = 16'h000A;
  localparam logic [DATA_W-1:0] DIFF_MAX = 16'h0064;

  // Setting table: first number, ranges and reset values
  localparam int NSET = 4;
  localparam logic [NUM_W-1:0] SET_BASE = 8'h01;
  localparam logic [DATA_W-1:0] SET_MIN [NSET] =
    '{16'h0005, 16'h0005, 16'h0005, 16'h000A};
  localparam logic [DATA_W-1:0] SET_MAX [NSET] =
    '{16'h0032, 16'h0BB8, 16'h0190, 16'h0064};
  localparam logic [DATA_W-1:0] SET_RST [NSET] =
    '{16'h000A, 16'h0005, 16'h0014, 16'h0032};

endpackage

/* design/rrpa_top.sv */
// Remote parameter access: readouts, settings and password gate
// Function
// - Master reads inputs, flags, settings, records
// - Only writable parameters accept serial writes
// - Out-of-range setting writes rejected, old kept
// - Serial setting writes need open password, default 1
// - Open via open parameter, close via close
// - Password comes up closed after restart
// - Open, then close parameter stores new password
// - Front panel overwrites password directly
// - Seventh wrong entry forces password zero
// - Read-only currents, difference, three control states
// - Control readout one while input energized
// - Readouts clamp to documented measuring ranges
// - State readouts follow signal level now
// - Recorded flags latch until register reset
// - Start/trip flags for all stages, difference trip
`timescale 1ns/1ps

module rrpa_top
  import rrpa_pkg::*;
#(
  // Wrong serial entries that lock the password
  parameter int LOCK_AFTER = int'(FAIL_LIMIT)
)
(
  // Clock and reset
  input  wire  logic                     clock,
  input  wire  logic                     rst,
  // Serial request
  input  wire  logic                     req_valid,
  input  wire  logic                     req_write,
  input  wire  logic [1:0]               req_kind,
  input  wire  logic [NUM_W-1:0]         req_num,
  input  wire  logic [DATA_W-1:0]        req_wdata,
  // Serial answer
  output logic                           rsp_valid,
  output logic                           rsp_ok,
  output logic [DATA_W-1:0]              rsp_rdata,
  // Front panel
  input  wire  logic                     fp_pw_write,
  input  wire  logic [PW_W-1:0]          fp_pw_value,
  input  wire  logic                     fp_set_write,
  input  wire  logic [NUM_W-1:0]         fp_set_num,
  input  wire  logic [DATA_W-1:0]        fp_set_value,
  output logic                           fp_set_ok,
  // Measurements from the measuring logic
  input  wire  logic [DATA_W-1:0]        meas_phase_one,
  input  wire  logic [DATA_W-1:0]        meas_phase_two,
  input  wire  logic [DATA_W-1:0]        meas_phase_three,
  input  wire  logic [DATA_W-1:0]        meas_residual,
  input  wire  logic [DATA_W-1:0]        meas_difference,
  // Control input pins
  input  wire  logic                     control_input_a,
  input  wire  logic                     control_input_b,
  input  wire  logic                     remote_reset_input,
  // Stage start and trip levels
  input  wire  logic [NSTAGE-1:0]        stage_now,
  input  wire  logic                     regs_reset,
  // Status and settings
  output logic                           pw_is_open,
  output logic                           pw_is_locked,
  output logic [NSET*DATA_W-1:0]         settings
);

  typedef struct packed {
    logic [2:0]              ctl_s1;
    logic [2:0]              ctl_s2;
    logic [NSTAGE-1:0]       seen;
    logic [PW_W-1:0]         pw;
    logic                    open;
    logic [2:0]              fails;
    logic                    locked;
    logic [NSET-1:0][DATA_W-1:0] set;
    logic                    rsp_v;
    logic                    rsp_ok;
    logic [DATA_W-1:0]       rdata;
    logic                    fp_ok;
  } rrpa_state_t;

  rrpa_state_t state_q;
  rrpa_state_t state_d;

  // Clamp a measurement into its reporting window
  function automatic logic [DATA_W-1:0] rrpa_clamp(
    input logic [DATA_W-1:0] v,
    input logic [DATA_W-1:0] lo,
    input logic [DATA_W-1:0] hi
  );
    logic [DATA_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end
    if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Setting index decode, shared by panel and bus
  function automatic logic rrpa_set_hit(
    input logic [NUM_W-1:0] num
  );
    return (num >= SET_BASE) &&
           (num < SET_BASE + NUM_W'(NSET));
  endfunction

  function automatic logic [1:0] rrpa_set_idx(
    input logic [NUM_W-1:0] num
  );
    logic [NUM_W-1:0] d;
    d = num - SET_BASE;
    return d[1:0];
  endfunction

  function automatic logic rrpa_in_range(
    input logic [1:0]        idx,
    input logic [DATA_W-1:0] v
  );
    return (v >= SET_MIN[idx]) && (v <= SET_MAX[idx]);
  endfunction

  // Password value check, shared by panel and bus
  function automatic logic rrpa_pw_legal(
    input logic [DATA_W-1:0] v
  );
    return (v <= DATA_W'(PW_MAX)) && (v[PW_W-1:0] >= PW_MIN);
  endfunction

  initial begin
    if (NSET > 4) begin
      $error("rrpa_top serves at most four settings");
    end
    // Three-bit fail counter; a single entry must not lock
    if (LOCK_AFTER < 2 || LOCK_AFTER > 7) begin
      $error("rrpa_top lock limit must be 2 to 7");
    end
  end

  logic [NUM_W-1:0]  out_off;
  logic [NUM_W-1:0]  seen_off;
  logic [1:0]        bus_idx;
  logic [1:0]        fp_idx;
  logic [PW_W-1:0]   wpw;
  logic              pw_range;

  assign out_off  = req_num - OUT_NOW_BASE;
  assign seen_off = req_num - OUT_SEEN_BASE;
  assign bus_idx  = rrpa_set_idx(req_num);
  assign fp_idx   = rrpa_set_idx(fp_set_num);
  assign wpw      = req_wdata[PW_W-1:0];
  assign pw_range = rrpa_pw_legal(req_wdata);

  always_comb begin
    logic bad;
    bad = 1'b0;
    state_d = state_q;
    state_d.rsp_v  = req_valid;
    state_d.rsp_ok = 1'b0;
    state_d.rdata  = '0;
    state_d.fp_ok  = 1'b0;
    // Pins pass two flops before any use
    state_d.ctl_s1 = {remote_reset_input, control_input_b,
                      control_input_a};
    state_d.ctl_s2 = state_q.ctl_s1;
    if (regs_reset) begin
      state_d.seen = stage_now;
    end else begin
      state_d.seen = state_q.seen | stage_now;
    end

    // Panel writes have no password gate
    // panel range check
    if (fp_set_write && rrpa_set_hit(fp_set_num) &&
        rrpa_in_range(fp_idx, fp_set_value)) begin
      state_d.set[fp_idx] = fp_set_value;
      state_d.fp_ok = 1'b1;
    end

    if (req_valid && !req_write) begin
      unique case (req_kind)
        RRPA_KIND_IN: begin
          state_d.rsp_ok = 1'b1;
          unique case (req_num)
            IN_PH1:  state_d.rdata =
                       rrpa_clamp(meas_phase_one, '0, PH_MAX);
            IN_PH2:  state_d.rdata =
                       rrpa_clamp(meas_phase_two, '0, PH_MAX);
            IN_PH3:  state_d.rdata =
                       rrpa_clamp(meas_phase_three, '0, PH_MAX);
            IN_RES:  state_d.rdata =
                       rrpa_clamp(meas_residual, '0, RES_MAX);
            IN_DIFF: state_d.rdata =
                       rrpa_clamp(meas_difference, DIFF_MIN,
                                  DIFF_MAX);
            IN_CTLA: state_d.rdata = DATA_W'(state_q.ctl_s2[0]);
            IN_CTLB: state_d.rdata = DATA_W'(state_q.ctl_s2[1]);
            IN_RRST: state_d.rdata = DATA_W'(state_q.ctl_s2[2]);
            default: state_d.rsp_ok = 1'b0;
          endcase
        end
        RRPA_KIND_OUT: begin
          if (out_off < NUM_W'(NSTAGE)) begin
            state_d.rsp_ok = 1'b1;
            state_d.rdata  = DATA_W'(stage_now[out_off[3:0]]);
          end else if (seen_off < NUM_W'(NSTAGE)) begin
            state_d.rsp_ok = 1'b1;
            state_d.rdata  =
              DATA_W'(state_q.seen[seen_off[3:0]]);
          end
        end
        RRPA_KIND_SET: begin
          if (rrpa_set_hit(req_num)) begin
            state_d.rsp_ok = 1'b1;
            state_d.rdata  = state_q.set[bus_idx];
          end
        end
        RRPA_KIND_VAR: begin
          // Password parameters are write-only
          state_d.rsp_ok = 1'b0;
        end
      endcase
    end

    if (req_valid && req_write) begin
      unique case (req_kind)
        RRPA_KIND_VAR: begin
          if (req_num == VAR_PW_OPEN) begin
            if (state_q.pw == PW_LOCKED) begin
              bad = 1'b0;
            end else if (pw_range && wpw == state_q.pw) begin
              state_d.open   = 1'b1;
              state_d.fails  = '0;
              state_d.rsp_ok = 1'b1;
            end else begin
              bad = 1'b1;
            end
          end else if (req_num == VAR_PW_CLOSE) begin
            if (state_q.pw == PW_LOCKED) begin
              bad = 1'b0;
            end else if (pw_range && wpw == state_q.pw) begin
              state_d.open   = 1'b0;
              state_d.rsp_ok = 1'b1;
            end else if (state_q.open && pw_range) begin
              state_d.pw     = wpw;
              state_d.rsp_ok = 1'b1;
            end else begin
              bad = 1'b1;
            end
          end
        end
        RRPA_KIND_SET: begin
          if (state_q.open && rrpa_set_hit(req_num) &&
              rrpa_in_range(bus_idx, req_wdata)) begin
            state_d.set[bus_idx] = req_wdata;
            state_d.rsp_ok = 1'b1;
          end
        end
        default: begin
          state_d.rsp_ok = 1'b0;
        end
      endcase
    end

    if (bad) begin
      if (state_q.fails == 3'(LOCK_AFTER - 1)) begin
        state_d.pw    = PW_LOCKED;
        state_d.open  = 1'b0;
        state_d.fails = '0;
      end else begin
        state_d.fails = state_q.fails + 3'h1;
      end
    end

    if (fp_pw_write && rrpa_pw_legal(DATA_W'(fp_pw_value))) begin
      state_d.pw    = fp_pw_value;
      state_d.fails = '0;
    end
    // Registered so the status pin comes from a flop
    state_d.locked = (state_d.pw == PW_LOCKED);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q        <= '0;
      state_q.pw     <= PW_DEFAULT;
      state_q.open   <= 1'b0;
      for (int i = 0; i < NSET; i++) begin
        state_q.set[i] <= SET_RST[i];
      end
    end else begin
      state_q <= state_d;
    end
  end

  assign rsp_valid    = state_q.rsp_v;
  assign rsp_ok       = state_q.rsp_ok;
  assign rsp_rdata    = state_q.rdata;
  assign fp_set_ok    = state_q.fp_ok;
  assign pw_is_open   = state_q.open;
  assign pw_is_locked = state_q.locked;
  assign settings     = state_q.set;

endmodule

/* test/rrpa_assertions.sv */
// Port checker for the remote parameter access block
`timescale 1ns/1ps
module rrpa_assertions
  import rrpa_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Serial request and answer
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic [1:0]        req_kind,
  input wire logic [NUM_W-1:0]  req_num,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic              rsp_valid,
  input wire logic              rsp_ok,
  input wire logic [DATA_W-1:0] rsp_rdata,
  // Panel, measurement and status
  input wire logic              fp_pw_write,
  input wire logic              fp_set_write,
  input wire logic [DATA_W-1:0] meas_phase_one,
  input wire logic              pw_is_open,
  input wire logic              pw_is_locked,
  input wire logic [63:0]       settings
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_refused;
    rsp_valid && !rsp_ok;
  endsequence
  sequence s_set_wr;
    req_valid && req_write && req_kind == RRPA_KIND_SET;
  endsequence
  chk_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("no answer after request");
  chk_no_stray: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  chk_ro_write: assert property (req_valid && req_write &&
    req_kind inside {RRPA_KIND_IN, RRPA_KIND_OUT} |=> s_refused)
    else $error("read-only write accepted");
  chk_closed_set: assert property (s_set_wr ##0
    (!pw_is_open && !fp_set_write) |=> s_refused ##0 $stable(settings))
    else $error("setting written while closed");
  chk_range_set: assert property (s_set_wr ##0
    (req_num == SET_BASE && req_wdata > SET_MAX[0]) |=> s_refused)
    else $error("out of range setting accepted");
  chk_var_read: assert property (req_valid && !req_write &&
    req_kind == RRPA_KIND_VAR |=> s_refused)
    else $error("password parameter readable");
  chk_locked_refuse: assert property (pw_is_locked &&
    !fp_pw_write && req_valid && req_kind == RRPA_KIND_VAR
    |=> s_refused ##0 !pw_is_open)
    else $error("locked password opened");
  chk_lock_closed: assert property (pw_is_locked |-> !pw_is_open)
    else $error("locked but open");
  chk_phase_clamp: assert property (req_valid && !req_write &&
    req_kind == RRPA_KIND_IN && req_num == IN_PH1 &&
    meas_phase_one > PH_MAX |=> rsp_rdata == PH_MAX)
    else $error("phase readout not clamped");
endmodule

bind rrpa_top rrpa_assertions chk (.clock, .rst, .req_valid,
  .req_write, .req_kind, .req_num, .req_wdata, .rsp_valid, .rsp_ok,
  .rsp_rdata, .fp_pw_write, .fp_set_write, .meas_phase_one,
  .pw_is_open, .pw_is_locked, .settings);

/* test/rrpa_master.sv */
// Serial bus master model for the parameter access block
`timescale 1ns/1ps
module rrpa_master
  import rrpa_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Request
  output logic                   req_valid,
  output logic                   req_write,
  output logic [1:0]             req_kind,
  output logic [NUM_W-1:0]       req_num,
  output logic [DATA_W-1:0]      req_wdata,
  // Answer
  input  wire logic              rsp_valid,
  input  wire logic              rsp_ok,
  input  wire logic [DATA_W-1:0] rsp_rdata
);
  initial begin
    {req_valid, req_write, req_kind, req_num, req_wdata} = '0;
  end
  task automatic xfer(input logic w, input logic [1:0] k,
    input logic [NUM_W-1:0] n, input logic [DATA_W-1:0] d,
    output logic ok, output logic [DATA_W-1:0] q);
    @(posedge clock);
    #1 {req_valid, req_write, req_kind, req_num, req_wdata} = {1'h1, w, k, n, d};
    @(posedge clock);
    #1 ok = rsp_valid && rsp_ok;
    q = rsp_rdata;
    // Stale kind, number and data inverted so a lost strobe never looks valid
    {req_valid, req_kind, req_num, req_wdata} = {1'h0, ~k, ~n, ~d};
  endtask
endmodule

/* test/tb.sv */
// Testbench for the remote parameter access block
`timescale 1ns/1ps
module tb;
  import rrpa_pkg::*;
  localparam logic [1:0] KI = RRPA_KIND_IN;
  localparam logic [1:0] KO = RRPA_KIND_OUT;
  localparam logic [1:0] KV = RRPA_KIND_VAR;
  localparam logic [1:0] KS = RRPA_KIND_SET;
  logic clock, rst, req_valid, req_write, rsp_valid, rsp_ok, ok;
  logic fp_pw_write, fp_set_write, fp_set_ok, ca, cb, cr, regs_reset;
  logic pw_is_open, pw_is_locked;
  logic [1:0]        req_kind;
  logic [NUM_W-1:0]  req_num, fp_set_num;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, fp_set_value, q;
  logic [DATA_W-1:0] p1, p2, p3, pr, pd;
  logic [PW_W-1:0]   fp_pw_value;
  logic [NSTAGE-1:0] stage_now;
  logic [63:0]       settings;
  int fails, samples_checked, cycles;
  rrpa_master m (.clock, .req_valid, .req_write, .req_kind, .req_num,
    .req_wdata, .rsp_valid, .rsp_ok, .rsp_rdata);
  rrpa_top dut (.clock, .rst, .req_valid, .req_write, .req_kind,
    .req_num, .req_wdata, .rsp_valid, .rsp_ok, .rsp_rdata, .fp_pw_write,
    .fp_pw_value, .fp_set_write, .fp_set_num, .fp_set_value, .fp_set_ok,
    .meas_phase_one(p1), .meas_phase_two(p2), .meas_phase_three(p3),
    .meas_residual(pr), .meas_difference(pd), .control_input_a(ca),
    .control_input_b(cb), .remote_reset_input(cr), .stage_now,
    .regs_reset, .pw_is_open, .pw_is_locked, .settings);
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [1:0] k, input logic [7:0] n,
    input logic [15:0] e);
    m.xfer(1'h0, k, n, 16'h0000, ok, q);
    check(16'(ok), 16'h0001);
    check(q, e);
  endtask
  task automatic wr(input logic [1:0] k, input logic [7:0] n,
    input logic [15:0] d, input logic e);
    m.xfer(1'h1, k, n, d, ok, q);
    check(16'(ok), 16'(e));
  endtask
  task automatic fp_pw(input logic [PW_W-1:0] v);
    @(posedge clock);
    #1 {fp_pw_write, fp_pw_value} = {1'h1, v};
    @(posedge clock);
    #1 fp_pw_write = 1'h0;
  endtask
  task automatic fp_set(input logic [15:0] v, input logic e);
    @(posedge clock);
    #1 {fp_set_write, fp_set_num, fp_set_value} = {1'h1, 8'h02, v};
    @(posedge clock);
    #1 fp_set_write = 1'h0;
    check(16'(fp_set_ok), 16'(e));
  endtask
  task automatic reset_check;
    check(16'(pw_is_open), 16'h0000);
    for (int i = 0; i < NSET; i++) begin
      check(settings[i*16 +: 16], SET_RST[i]);
    end
  endtask
  // Ceiling well above the roughly 90 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {rst, fp_pw_write, fp_set_write, regs_reset} = 4'h8;
    {fp_pw_value, fp_set_num, fp_set_value} = '0;
    {p1, p2, p3, pr, pd} = {16'h0050, 16'h0010, 16'h003F, 16'h0030, 16'h0002};
    {ca, cb, cr, stage_now} = {3'h5, 11'h000};
    repeat (5) @(posedge clock);
    #1 rst = 1'h0;
    reset_check();
    rd(KI, IN_PH1, 16'h003F);
    rd(KI, IN_PH2, 16'h0010);
    rd(KI, IN_PH3, 16'h003F);
    rd(KI, IN_RES, 16'h0015);
    rd(KI, IN_DIFF, 16'h000A);
    rd(KI, IN_CTLA, 16'h0001);
    rd(KI, IN_CTLB, 16'h0000);
    rd(KI, IN_RRST, 16'h0001);
    ca = 1'h0;
    repeat (3) @(posedge clock);
    rd(KI, IN_CTLA, 16'h0000);
    $display("test readouts done");
    stage_now = 11'h001;
    @(posedge clock);
    #1 stage_now = 11'h400;
    rd(KO, OUT_NOW_BASE, 16'h0000);
    rd(KO, OUT_SEEN_BASE, 16'h0001);
    rd(KO, 8'h0B, 16'h0001);
    rd(KO, 8'h1F, 16'h0001);
    {stage_now, regs_reset} = 12'h001;
    @(posedge clock);
    #1 regs_reset = 1'h0;
    rd(KO, OUT_SEEN_BASE, 16'h0000);
    $display("test flags done");
    wr(KI, IN_PH1, 16'h0001, 1'h0);
    wr(KS, SET_BASE, 16'h0020, 1'h0);
    wr(KV, VAR_PW_OPEN, 16'h0001, 1'h1);
    check(16'(pw_is_open), 16'h0001);
    wr(KS, SET_BASE, 16'h0032, 1'h1);
    wr(KS, SET_BASE, 16'h0033, 1'h0);
    check(settings[15:0], 16'h0032);
    rd(KS, SET_BASE, 16'h0032);
    m.xfer(1'h0, KV, VAR_PW_CLOSE, 16'h0000, ok, q);
    check(16'(ok), 16'h0000);
    $display("test settings done");
    wr(KV, VAR_PW_CLOSE, 16'h0005, 1'h1);
    check(16'(pw_is_open), 16'h0001);
    wr(KV, VAR_PW_CLOSE, 16'h0005, 1'h1);
    check(16'(pw_is_open), 16'h0000);
    wr(KV, VAR_PW_CLOSE, 16'h0003, 1'h0);
    wr(KV, VAR_PW_OPEN, 16'h0001, 1'h0);
    $display("test password change done");
    fp_pw(10'h009);
    for (int i = 0; i < 6; i++) begin
      wr(KV, VAR_PW_OPEN, 16'h0002, 1'h0);
    end
    check(16'(pw_is_locked), 16'h0000);
    wr(KV, VAR_PW_OPEN, 16'h0002, 1'h0);
    check(16'(pw_is_locked), 16'h0001);
    wr(KV, VAR_PW_OPEN, 16'h0009, 1'h0);
    fp_pw(10'h001);
    wr(KV, VAR_PW_OPEN, 16'h0001, 1'h1);
    fp_set(16'h0100, 1'h1);
    check(settings[31:16], 16'h0100);
    fp_set(16'h0001, 1'h0);
    $display("test lockout done");
    rst = 1'h1;
    repeat (2) @(posedge clock);
    #1 rst = 1'h0;
    reset_check();
    wr(KV, VAR_PW_OPEN, 16'h0001, 1'h1);
    $display("test restart done");
    end_sim();
  end
endmodule
